// ### hw/sdec_pkg.sv
// Contract
// - Split the 4 GB space into code, SRAM, peripheral, external RAM/peripheral, internal peripheral regions.
// - Code region maps flash from zero; 32 KB SRAM blocks below and above 0x20000000.
// - SRAM region holds a 1 MB bit area at its base, alias area at 0x22000000.
// - Alias write sets or clears one SRAM bit from data bit 0, others untouched.
// - Alias read returns 0 or 1, the current value of that SRAM bit.
// - Unaligned word and half-word accesses are accepted, split into aligned transfers.
// - Instruction and data code buses carry only program code range addresses.
// - System bus carries data from SRAM base to external peripherals, and from 0xE0100000.
// - System bus also takes instruction fetches in the SRAM region, possibly slower.
// - Private peripheral bus serves system control, interrupt controller, debug and trace registers.
// - Select external memory interface control registers for 0x40005400-0x400054FF.
// - External RAM accesses go to the external memory interface, 24 address bits.
// - External data bus is 8 or 16 bits wide by configuration.
// - Synchronous or asynchronous memory, one type only at any time.
// - Each external memory access takes four bus clock cycles.
// - Instruction fetch from external RAM allowed only when memory is 16 bits wide.
// - No read or write protection on the external memory region.
package sdec_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] EXT_RAM_BASE = 32'h6000_0000;
  localparam logic [31:0] EXT_PERIPH_BASE = 32'ha000_0000;
  localparam logic [31:0] INT_PERIPH_BASE = 32'he000_0000;
  localparam logic [31:0] SYS_UPPER_BASE = 32'he010_0000;
  localparam logic [31:0] SRAM_CODE_BASE = 32'h1fff_8000;
  localparam logic [31:0] SRAM_BLOCK_BYTES = 32'h0000_8000;
  localparam logic [31:0] FLASH_BYTES_DEF = 32'h0004_0000;
  localparam logic [31:0] EXT_CTRL_FIRST = 32'h4000_5400;
  localparam logic [31:0] EXT_CTRL_LAST = 32'h4000_54ff;

  // ----------------------------------------------------------------
  // Bit-band alias fields
  // ----------------------------------------------------------------
  localparam logic [31:0] BB_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] BB_ALIAS_END = 32'h2400_0000;
  localparam int BB_BYTE_LSB = 5;
  localparam int BB_BYTE_MSB = 24;
  localparam int BB_BIT_LSB = 2;
  localparam int BB_BIT_MSB = 4;

  // ----------------------------------------------------------------
  // External memory timing and width
  // ----------------------------------------------------------------
  localparam int EXT_ADDR_BITS = 24;
  localparam logic [3:0] EXT_ACCESS_CYCLES = 4'h4;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RGN_CODE, RGN_SRAM, RGN_PERIPH, RGN_EXT_RAM, RGN_EXT_PERIPH, RGN_INT_PERIPH
  } sdec_region_t;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_INSTR_CODE_BUS, TGT_DATA_CODE_BUS, TGT_SYS_BUS, TGT_PRIVATE_PERIPH_BUS, TGT_EXT_MEM_IF
  } sdec_target_t;

  typedef enum logic [1:0] {MEM_NONE, MEM_FLASH, MEM_SRAM_CODE, MEM_SRAM_SYS} sdec_mem_t;

  typedef enum logic [1:0] {PH_IDLE, PH_BUS, PH_EXT} sdec_phase_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic fetch;
    logic [31:0] wdata;
  } sdec_up_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } sdec_up_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic lock;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sdec_dn_req_t;

  typedef struct packed {
    logic cs;
    logic we;
    logic sync;
    logic wide;
    logic [EXT_ADDR_BITS-1:0] addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } sdec_ext_req_t;

  typedef struct packed {
    sdec_phase_t phase;
    logic rdy;
    logic [31:0] base;
    logic [31:0] wdata;
    logic [31:0] acc;
    logic write;
    logic bb;
    logic bb_wr;
    logic [4:0] bbit;
    logic [1:0] cur;
    logic [2:0] rem;
    logic [1:0] off;
    logic [2:0] n;
    logic [3:0] cnt;
    sdec_target_t sel;
    sdec_dn_req_t dn;
    sdec_ext_req_t ext;
    sdec_up_rsp_t rsp;
    sdec_region_t region;
    sdec_mem_t mem;
    logic ctrl_sel;
  } sdec_state_t;

endpackage

// ### hw/sdec_top.sv
module sdec_top
  import sdec_pkg::*;
#(
  parameter logic [31:0] FLASH_BYTES = FLASH_BYTES_DEF,
  parameter logic [3:0] EXT_CYCLES = EXT_ACCESS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Core side
  input wire sdec_up_req_t up_req,
  output logic up_ready,
  output sdec_up_rsp_t up_rsp,
  // External memory configuration
  input wire logic ext_wide,
  input wire logic ext_sync,
  // Fabric side
  output sdec_dn_req_t dn_req,
  output sdec_target_t dn_sel,
  input wire logic dn_done,
  input wire logic [31:0] dn_rdata,
  // External memory side
  output sdec_ext_req_t ext_req,
  input wire logic [15:0] ext_rdata,
  // Decode status
  output sdec_region_t region,
  output sdec_mem_t mem_sel,
  output logic ext_ctrl_sel
);

  sdec_state_t r;
  sdec_state_t nx;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic sdec_region_t region_of(input logic [31:0] a);
    if (a < SRAM_BASE) return RGN_CODE;
    else if (a < PERIPH_BASE) return RGN_SRAM;
    else if (a < EXT_RAM_BASE) return RGN_PERIPH;
    else if (a < EXT_PERIPH_BASE) return RGN_EXT_RAM;
    else if (a < INT_PERIPH_BASE) return RGN_EXT_PERIPH;
    else return RGN_INT_PERIPH;
  endfunction

  function automatic sdec_target_t target_of(input logic [31:0] a, input logic fetch);
    if (a < SRAM_BASE) return fetch ? TGT_INSTR_CODE_BUS : TGT_DATA_CODE_BUS;
    else if (a >= EXT_RAM_BASE && a < EXT_PERIPH_BASE) return TGT_EXT_MEM_IF;
    else if (a >= INT_PERIPH_BASE && a < SYS_UPPER_BASE) return TGT_PRIVATE_PERIPH_BUS;
    else return TGT_SYS_BUS;
  endfunction

  function automatic sdec_mem_t mem_of(input logic [31:0] a);
    if (a < FLASH_BYTES) return MEM_FLASH;
    else if (a >= SRAM_CODE_BASE && a < SRAM_BASE) return MEM_SRAM_CODE;
    else if (a >= SRAM_BASE && a < SRAM_BASE + SRAM_BLOCK_BYTES) return MEM_SRAM_SYS;
    else return MEM_NONE;
  endfunction

  function automatic logic [2:0] bytes_of(input logic [1:0] size);
    unique case (size)
      SIZE_BYTE: return 3'h1;
      SIZE_HALF: return 3'h2;
      default: return 3'h4;
    endcase
  endfunction

  // Fetches only where code may run; external RAM holds no protection otherwise
  function automatic logic refused(input sdec_up_req_t q, input logic wide);
    sdec_target_t t;
    t = target_of(q.addr, q.fetch);
    if (q.size == 2'h3) return 1'b1;
    if (q.fetch && t == TGT_SYS_BUS && region_of(q.addr) != RGN_SRAM) return 1'b1;
    if (q.fetch && t == TGT_PRIVATE_PERIPH_BUS) return 1'b1;
    if (q.fetch && t == TGT_EXT_MEM_IF && !wide) return 1'b1;
    return 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // Chunk issue: one aligned word, or one external bus unit
  // ----------------------------------------------------------------
  function automatic sdec_state_t start_chunk(input sdec_state_t s);
    sdec_state_t o;
    logic [31:0] a;
    logic [2:0] room;
    logic [1:0] lane;
    logic [1:0] j;
    o = s;
    a = s.base + {30'h0, s.cur};
    if (s.sel == TGT_EXT_MEM_IF) begin
      o.off = s.ext.wide ? {1'b0, a[0]} : 2'h0;
      room = s.ext.wide ? 3'h2 - {2'h0, a[0]} : 3'h1;
    end else begin
      o.off = a[1:0];
      room = 3'h4 - {1'b0, a[1:0]};
    end
    o.n = (room < s.rem) ? room : s.rem;
    o.dn.be = 4'h0;
    o.dn.wdata = 32'h0;
    o.ext.be = 2'h0;
    o.ext.wdata = 16'h0;
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < o.n) begin
        lane = o.off + 2'(k);
        j = s.cur + 2'(k);
        if (s.sel == TGT_EXT_MEM_IF) begin
          o.ext.be[lane[0]] = 1'b1;
          o.ext.wdata[8*lane[0] +: 8] = s.wdata[8*j +: 8];
        end else begin
          o.dn.be[lane] = 1'b1;
          o.dn.wdata[8*lane +: 8] = s.wdata[8*j +: 8];
        end
      end
    end
    if (s.sel == TGT_EXT_MEM_IF) begin
      o.ext.cs = 1'b1;
      o.ext.we = s.write;
      o.ext.addr = s.ext.wide ? {a[EXT_ADDR_BITS-1:1], 1'b0} : a[EXT_ADDR_BITS-1:0];
      o.cnt = EXT_CYCLES - 4'h1;
      o.phase = PH_EXT;
    end else begin
      o.dn.valid = 1'b1;
      // Alias access reads first, so the write is held back until the bit merge
      o.dn.write = s.write && !s.bb;
      o.dn.lock = s.bb;
      o.dn.addr = {a[31:2], 2'h0};
      if (s.bb) begin
        o.dn.be = 4'hf;
      end
      o.phase = PH_BUS;
    end
    return o;
  endfunction

  // Gather read lanes, then issue the next chunk or answer
  function automatic sdec_state_t collect(input sdec_state_t s, input logic [31:0] data);
    sdec_state_t o;
    logic [1:0] lane;
    logic [1:0] j;
    o = s;
    if (!s.write) begin
      for (int k = 0; k < 4; k++) begin
        if (3'(k) < s.n) begin
          lane = s.off + 2'(k);
          j = s.cur + 2'(k);
          o.acc[8*j +: 8] = data[8*lane +: 8];
        end
      end
      if (s.bb) begin
        o.acc = {31'h0, data[s.bbit]};
      end
    end
    o.cur = s.cur + s.n[1:0];
    o.rem = s.rem - s.n;
    if (o.rem == 3'h0) begin
      o.phase = PH_IDLE;
      o.rsp.valid = 1'b1;
      o.rsp.err = 1'b0;
      o.rsp.rdata = o.acc;
    end else begin
      o = start_chunk(o);
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] merged;
    logic [19:0] bbyte;
    merged = 32'h0;
    bbyte = 20'h0;
    nx = r;
    nx.rsp.valid = 1'b0;
    unique case (r.phase)
      PH_IDLE: begin
        // Nothing is taken in the first cycle after reset, while ready is still low
        if (up_req.valid && r.rdy) begin
          nx.base = up_req.addr;
          nx.wdata = up_req.wdata;
          nx.write = up_req.write;
          nx.acc = 32'h0;
          nx.cur = 2'h0;
          nx.rem = bytes_of(up_req.size);
          nx.bb = 1'b0;
          nx.bb_wr = 1'b0;
          nx.bbit = 5'h0;
          nx.region = region_of(up_req.addr);
          nx.mem = mem_of(up_req.addr);
          nx.ctrl_sel = up_req.addr >= EXT_CTRL_FIRST && up_req.addr <= EXT_CTRL_LAST;
          nx.sel = target_of(up_req.addr, up_req.fetch);
          // Mode is caught per access, so one memory type stands for a whole access
          nx.ext.wide = ext_wide;
          nx.ext.sync = ext_sync;
          if (!up_req.fetch && up_req.addr >= BB_ALIAS_BASE && up_req.addr < BB_ALIAS_END) begin
            bbyte = up_req.addr[BB_BYTE_MSB:BB_BYTE_LSB];
            nx.bb = 1'b1;
            nx.base = SRAM_BASE | {12'h0, bbyte[19:2], 2'h0};
            nx.bbit = {bbyte[1:0], up_req.addr[BB_BIT_MSB:BB_BIT_LSB]};
            nx.rem = 3'h4;
            nx.mem = mem_of(SRAM_BASE | {12'h0, bbyte[19:2], 2'h0});
          end
          if (refused(up_req, ext_wide)) begin
            nx.sel = TGT_NONE;
            nx.rsp.valid = 1'b1;
            nx.rsp.err = 1'b1;
            nx.rsp.rdata = 32'h0;
          end else begin
            nx = start_chunk(nx);
          end
        end
      end
      PH_BUS: begin
        if (dn_done) begin
          if (r.bb && r.write && !r.bb_wr) begin
            merged = dn_rdata;
            merged[r.bbit] = r.wdata[0];
            nx.bb_wr = 1'b1;
            nx.dn.write = 1'b1;
            nx.dn.wdata = merged;
          end else begin
            nx.dn.valid = 1'b0;
            nx.dn.write = 1'b0;
            nx.dn.lock = 1'b0;
            nx = collect(nx, dn_rdata);
          end
        end
      end
      PH_EXT: begin
        if (r.cnt != 4'h0) begin
          nx.cnt = r.cnt - 4'h1;
        end else begin
          nx.ext.cs = 1'b0;
          nx.ext.we = 1'b0;
          nx = collect(nx, {16'h0, ext_rdata});
        end
      end
      default: begin
        nx.phase = PH_IDLE;
      end
    endcase
    nx.rdy = (nx.phase == PH_IDLE);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= nx;
    end
  end

  assign up_ready = r.rdy;
  assign up_rsp = r.rsp;
  assign dn_req = r.dn;
  assign dn_sel = r.sel;
  assign ext_req = r.ext;
  assign region = r.region;
  assign mem_sel = r.mem;
  assign ext_ctrl_sel = r.ctrl_sel;

endmodule

// ### tb/sdec_top_monitor.sv
module sdec_top_monitor
  import sdec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Core side
  input wire sdec_up_req_t up_req,
  input wire logic up_ready,
  input wire sdec_up_rsp_t up_rsp,
  input wire logic ext_wide,
  // Fabric and external side
  input wire sdec_dn_req_t dn_req,
  input wire sdec_target_t dn_sel,
  input wire logic dn_done,
  input wire sdec_ext_req_t ext_req,
  // Decode status
  input wire sdec_region_t region,
  input wire logic ext_ctrl_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic alias_rd_reg;
  logic alias_wr_reg;
  assign tk = clk_en && up_ready && up_req.valid;
  // Alias flags held until the answer
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alias_rd_reg <= 1'b0;
      alias_wr_reg <= 1'b0;
    end else if (tk) begin
      alias_rd_reg <= !up_req.write && !up_req.fetch && up_req.addr[31:25] == 7'h11;
      alias_wr_reg <= up_req.write && !up_req.fetch && up_req.addr[31:25] == 7'h11;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ext_beat;
    $rose(ext_req.cs) |-> ext_req.cs [*4];
  endproperty
  a_ext_beat: assert property (p_ext_beat) else $error("ext beat too short");
  property p_ext_route;
    ext_req.cs |-> dn_sel == TGT_EXT_MEM_IF && !dn_req.valid;
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("ext access not on ext port");
  property p_code_bus;
    dn_req.valid && dn_sel inside {TGT_INSTR_CODE_BUS, TGT_DATA_CODE_BUS} |-> dn_req.addr < SRAM_BASE;
  endproperty
  a_code_bus: assert property (p_code_bus) else $error("code bus out of range");
  property p_sys_bus;
    dn_req.valid && dn_sel == TGT_SYS_BUS |-> dn_req.addr >= SRAM_BASE &&
      (dn_req.addr < INT_PERIPH_BASE || dn_req.addr >= SYS_UPPER_BASE);
  endproperty
  a_sys_bus: assert property (p_sys_bus) else $error("sys bus out of range");
  property p_ppb;
    dn_req.valid && dn_sel == TGT_PRIVATE_PERIPH_BUS |-> dn_req.addr[31:20] == 12'he00;
  endproperty
  a_ppb: assert property (p_ppb) else $error("private bus out of range");
  property p_alias_lock;
    alias_wr_reg && dn_req.valid && dn_req.lock && !dn_req.write && dn_done |=>
      dn_req.valid && dn_req.lock && dn_req.write;
  endproperty
  a_alias_lock: assert property (p_alias_lock) else $error("alias write not locked");
  property p_alias_rd;
    up_rsp.valid && alias_rd_reg |-> up_rsp.rdata[31:1] == 31'h0;
  endproperty
  a_alias_rd: assert property (p_alias_rd) else $error("alias read not single bit");
  property p_narrow_fetch;
    tk && up_req.fetch && up_req.addr[31:29] inside {3'h3, 3'h4} && !ext_wide |=> up_rsp.valid && up_rsp.err;
  endproperty
  a_narrow_fetch: assert property (p_narrow_fetch) else $error("narrow fetch not refused");
  property p_ctrl_sel;
    tk |=> ext_ctrl_sel == ($past(up_req.addr) >= EXT_CTRL_FIRST && $past(up_req.addr) <= EXT_CTRL_LAST);
  endproperty
  a_ctrl_sel: assert property (p_ctrl_sel) else $error("ext control select wrong");
  property p_ext_region;
    tk && up_req.addr[31:29] inside {3'h3, 3'h4} |=> region == RGN_EXT_RAM;
  endproperty
  a_ext_region: assert property (p_ext_region) else $error("ext region wrong");
endmodule

bind sdec_top sdec_top_monitor u_mon (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .up_req(up_req),
  .up_ready(up_ready), .up_rsp(up_rsp), .ext_wide(ext_wide), .dn_req(dn_req), .dn_sel(dn_sel),
  .dn_done(dn_done), .ext_req(ext_req), .region(region), .ext_ctrl_sel(ext_ctrl_sel));

// ### tb/sdec_fabric_model.sv
module sdec_fabric_model
  import sdec_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic slow,
  // Fabric
  input wire sdec_dn_req_t dn_req,
  output logic dn_done,
  output logic [31:0] dn_rdata,
  // External memory
  input wire sdec_ext_req_t ext_req,
  output logic [15:0] ext_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [7:0] xmem [256];
  logic [1:0] wait_cnt;
  logic [7:0] xa;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 2'h0;
    end else begin
      wait_cnt <= (dn_req.valid && !dn_done) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
  assign dn_done = dn_req.valid && (!slow || wait_cnt == 2'h2);
  // Idle lines toggle so a stale value never passes
  assign dn_rdata = dn_done ? mem[dn_req.addr[7:2]] : {16{clock, ~clock}};
  assign xa = ext_req.wide ? {ext_req.addr[7:1], 1'b0} : ext_req.addr[7:0];
  assign ext_rdata = ext_req.cs ? {xmem[xa + 8'h1], xmem[xa]} : {8{clock, ~clock}};
  always @(posedge clock) begin
    if (dn_done && dn_req.write) begin
      for (int i = 0; i < 4; i++) begin
        if (dn_req.be[i]) begin
          mem[dn_req.addr[7:2]][8*i +: 8] <= dn_req.wdata[8*i +: 8];
        end
      end
    end
    if (ext_req.cs && ext_req.we && (!ext_req.wide || ext_req.be[0])) begin
      xmem[xa] <= ext_req.wdata[7:0];
    end
    if (ext_req.cs && ext_req.we && ext_req.wide && ext_req.be[1]) begin
      xmem[xa + 8'h1] <= ext_req.wdata[15:8];
    end
  end
endmodule

// ### tb/test_system_address_decoder.sv
module test_system_address_decoder
  import sdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic ext_wide = 1'b1;
  logic ext_sync = 1'b0;
  logic slow = 1'b0;
  sdec_up_req_t up_req = '0;
  sdec_up_rsp_t up_rsp, rsp;
  sdec_dn_req_t dn_req;
  sdec_target_t dn_sel;
  sdec_ext_req_t ext_req;
  sdec_region_t region;
  sdec_mem_t mem_sel;
  logic up_ready, dn_done, ext_ctrl_sel;
  logic [31:0] dn_rdata;
  logic [15:0] ext_rdata;
  int num_errors = 0;
  int checks = 0;
  int lat;
  always #5 clock = ~clock;
  sdec_top u_dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .up_req(up_req), .up_ready(up_ready),
    .up_rsp(up_rsp), .ext_wide(ext_wide), .ext_sync(ext_sync), .dn_req(dn_req), .dn_sel(dn_sel),
    .dn_done(dn_done), .dn_rdata(dn_rdata), .ext_req(ext_req), .ext_rdata(ext_rdata), .region(region),
    .mem_sel(mem_sel), .ext_ctrl_sel(ext_ctrl_sel));
  sdec_fabric_model u_far (.clock(clock), .reset_n(reset_n), .slow(slow), .dn_req(dn_req), .dn_done(dn_done),
    .dn_rdata(dn_rdata), .ext_req(ext_req), .ext_rdata(ext_rdata));
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One core access; lat counts cycles from take to answer
  task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] sz, input logic f, input logic [31:0] d);
    int n;
    n = 0;
    up_req = {1'b1, a, w, sz, f, d};
    while (up_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
      #1;
    end
    if (n == 50) begin
      num_errors++;
    end
    @(posedge clock);
    #1;
    up_req.valid = 1'b0;
    n = 0;
    while (up_rsp.valid !== 1'b1 && n < 300) begin
      n++;
      @(posedge clock);
      #1;
    end
    if (n == 300) begin
      num_errors++;
    end
    lat = n;
    rsp = up_rsp;
  endtask
  task automatic t_sram();
    acc(32'h2000_0010, 1'b1, SIZE_WORD, 1'b0, 32'haabb_ccdd);
    acc(32'h2000_0014, 1'b1, SIZE_WORD, 1'b0, 32'h0);
    acc(32'h2000_0011, 1'b1, SIZE_WORD, 1'b0, 32'h4433_2211);
    slow = 1'b1;
    acc(32'h2000_0010, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("word0", rsp.rdata, 32'h3322_11dd);
    acc(32'h2000_0014, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("word1", rsp.rdata, 32'h0000_0044);
    cmp("slow latency", lat, 32'h3);
    slow = 1'b0;
    acc(32'h2000_0012, 1'b0, SIZE_HALF, 1'b0, 32'h0);
    cmp("half", rsp.rdata[15:0], 32'h3322);
    $display("test sram done");
  endtask
  task automatic t_band();
    acc(32'h2000_0000, 1'b1, SIZE_WORD, 1'b0, 32'h0000_00f0);
    acc(32'h2000_0004, 1'b1, SIZE_WORD, 1'b0, 32'h0);
    acc(32'h2200_000c, 1'b1, SIZE_WORD, 1'b0, 32'h1);
    acc(32'h2200_0010, 1'b1, SIZE_WORD, 1'b0, 32'h0);
    acc(32'h2200_0018, 1'b1, SIZE_WORD, 1'b0, 32'hffff_fffe);
    acc(32'h2200_00a4, 1'b1, SIZE_WORD, 1'b0, 32'h1);
    acc(32'h2200_000c, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("alias bit3", rsp.rdata, 32'h1);
    acc(32'h2200_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("alias bit0", rsp.rdata, 32'h0);
    acc(32'h2000_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("band word0", rsp.rdata, 32'h0000_00a8);
    acc(32'h2000_0004, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("band word1", rsp.rdata, 32'h0000_0200);
    $display("test band done");
  endtask
  task automatic t_ext();
    ext_sync = 1'b1;
    acc(32'h6000_0020, 1'b1, SIZE_WORD, 1'b0, 32'h8765_4321);
    cmp("wide latency", lat, 32'h8);
    cmp("ext sync", ext_req.sync, 1'b1);
    acc(32'h6000_0020, 1'b0, SIZE_WORD, 1'b1, 32'h0);
    cmp("wide fetch err", rsp.err, 1'b0);
    cmp("wide fetch", rsp.rdata, 32'h8765_4321);
    ext_wide = 1'b0;
    acc(32'h6000_0021, 1'b0, SIZE_BYTE, 1'b0, 32'h0);
    cmp("narrow byte", rsp.rdata[7:0], 32'h43);
    cmp("byte latency", lat, 32'h4);
    acc(32'h6000_0020, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp("narrow latency", lat, 32'h10);
    acc(32'h6000_0020, 1'b0, SIZE_WORD, 1'b1, 32'h0);
    cmp("narrow fetch", rsp.err, 1'b1);
    acc(32'h9fff_fffe, 1'b1, SIZE_HALF, 1'b0, 32'hbeef);
    acc(32'h9fff_fffe, 1'b0, SIZE_HALF, 1'b0, 32'h0);
    cmp("top half", rsp.rdata[15:0], 32'hbeef);
    ext_wide = 1'b1;
    $display("test ext done");
  endtask
  task automatic rt(input logic [31:0] a, input logic f, input logic [1:0] sz, input logic e,
    input sdec_target_t s, input sdec_region_t g, input sdec_mem_t m);
    acc(a, 1'b0, sz, f, 32'h0);
    cmp("refusal", rsp.err, e);
    cmp("target", dn_sel, s);
    cmp("region", region, g);
    cmp("memory", mem_sel, m);
    cmp("ext ctrl", ext_ctrl_sel, a >= EXT_CTRL_FIRST && a <= EXT_CTRL_LAST);
  endtask
  task automatic t_route();
    rt(32'h0000_0100, 1'b0, SIZE_WORD, 1'b0, TGT_DATA_CODE_BUS, RGN_CODE, MEM_FLASH);
    rt(32'h0000_0100, 1'b1, SIZE_WORD, 1'b0, TGT_INSTR_CODE_BUS, RGN_CODE, MEM_FLASH);
    rt(32'h1fff_8000, 1'b0, SIZE_WORD, 1'b0, TGT_DATA_CODE_BUS, RGN_CODE, MEM_SRAM_CODE);
    rt(32'h2000_7ffc, 1'b1, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_SRAM, MEM_SRAM_SYS);
    rt(32'h4000_53fc, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_PERIPH, MEM_NONE);
    rt(32'h4000_5400, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_PERIPH, MEM_NONE);
    rt(32'h4000_54fc, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_PERIPH, MEM_NONE);
    rt(32'h4000_5500, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_PERIPH, MEM_NONE);
    rt(32'ha000_0000, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_EXT_PERIPH, MEM_NONE);
    rt(32'he000_e000, 1'b0, SIZE_WORD, 1'b0, TGT_PRIVATE_PERIPH_BUS, RGN_INT_PERIPH, MEM_NONE);
    rt(32'he010_0000, 1'b0, SIZE_WORD, 1'b0, TGT_SYS_BUS, RGN_INT_PERIPH, MEM_NONE);
    rt(32'h4000_0000, 1'b1, SIZE_WORD, 1'b1, TGT_NONE, RGN_PERIPH, MEM_NONE);
    rt(32'he000_0000, 1'b1, SIZE_WORD, 1'b1, TGT_NONE, RGN_INT_PERIPH, MEM_NONE);
    rt(32'h2000_0000, 1'b0, 2'h3, 1'b1, TGT_NONE, RGN_SRAM, MEM_SRAM_SYS);
    $display("test route done");
  endtask
  // Whole run is about 130 cycles
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1;
    cmp("reset ready", up_ready, 1'b0);
    cmp("reset target", dn_sel, TGT_NONE);
    reset_n = 1'b1;
    t_sram();
    t_band();
    t_ext();
    t_route();
    results();
  end
endmodule
